// [hw/dibc_ctrl.sv]
// Inversion and blanking command decoder with panel-facing state
//
// Notes on behaviour
// - Command 20h, no parameters, clears colour inversion.
// - Command 21h, no parameters, sets colour inversion.
// - Inversion clear while already clear changes nothing.
// - Inversion set while already set changes nothing.
// - Command 28h enters blanked state; panel gets a blank page.
// - Command 29h leaves blanked state; frame memory shown again.
// - Blank and unblank never touch frame memory contents.
// - Blank and unblank change only the output-enable state.
// - Entering blanked state by command switches cleanly, at a frame boundary.
// - Blank while already blanked takes no action.
// - Unblank while already unblanked takes no action.
// - Power-on, hardware and software reset leave inversion cleared.
// - Power-on, hardware and software reset leave output blanked.
// - All four commands work in every display and sleep mode.
`default_nettype none

module dibc_ctrl
  import dibc_pkg::*;
#(
  parameter int DROP_CNT_W = 8
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Host byte stream
  input wire logic byte_valid_in,
  input wire logic byte_is_cmd_in,
  input wire logic [7:0] byte_in,
  // Software reset and scan timing
  input wire logic soft_rst_in,
  input wire logic frame_start_in,
  // Register port
  input wire logic [dibc_pkg::DIBC_ADDR_W-1:0] reg_addr_in,
  input wire logic [dibc_pkg::DIBC_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [dibc_pkg::DIBC_DATA_W-1:0] reg_rdata_out,
  // Panel scan path
  output logic invert_out,
  output logic blank_out,
  // Bytes for other decoders
  output logic fwd_valid_out,
  output logic fwd_is_cmd_out,
  output logic [7:0] fwd_byte_out
);

  import dibc_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  dibc_state_t state;
  dibc_state_t next_state;
  logic sw_cmd_pend;
  logic [7:0] sw_cmd_byte;
  logic ctrl_soft_rst;
  logic soft_rst_any;
  logic exec_valid;
  logic [7:0] exec_byte;
  logic exec_from_link;
  logic is_inv_clr;
  logic is_inv_set;
  logic is_blank;
  logic is_unblank;
  logic is_own;
  logic invert_flag;
  logic out_en_flag;
  logic blank_pend;
  logic drop_seen;
  logic drop_now;
  logic [7:0] last_cmd;
  logic [DROP_CNT_W-1:0] drop_cnt;

  // ----------------------------------------------------------------------
  // Command source selection
  // ----------------------------------------------------------------------
  // Link command bytes win; a register-issued byte waits for a free cycle
  assign exec_from_link = byte_valid_in && byte_is_cmd_in;
  assign exec_valid = exec_from_link || sw_cmd_pend;
  assign exec_byte = exec_from_link ? byte_in : sw_cmd_byte;
  assign ctrl_soft_rst = reg_wr_in && (reg_addr_in == DIBC_REG_CTRL) &&
                         reg_wdata_in[DIBC_CTRL_SOFT_RST_BIT];
  assign soft_rst_any = soft_rst_in || ctrl_soft_rst;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_cmd_pend <= 1'b0;
      sw_cmd_byte <= 8'h00;
    end else if (reg_wr_in && (reg_addr_in == DIBC_REG_CMD_ISSUE)) begin
      sw_cmd_pend <= 1'b1;
      sw_cmd_byte <= reg_wdata_in;
    end else if (sw_cmd_pend && !exec_from_link) begin
      sw_cmd_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // No mode input gates the decode: sleep, idle, partial alike
  assign is_inv_clr = exec_valid &&
                      (exec_byte == DIBC_INVERSION_CLEAR_CMD);
  assign is_inv_set = exec_valid &&
                      (exec_byte == DIBC_INVERSION_SET_CMD);
  assign is_blank = exec_valid &&
                    (exec_byte == DIBC_BLANK_OUTPUT_CMD);
  assign is_unblank = exec_valid &&
                      (exec_byte == DIBC_UNBLANK_OUTPUT_CMD);
  assign is_own = is_inv_clr || is_inv_set || is_blank || is_unblank;

  // ----------------------------------------------------------------------
  // State flags
  // ----------------------------------------------------------------------
  // Each flag only moves when its own pair of commands arrives or on a hardware or software reset
  dibc_flag #(
    .RESET_VAL(DIBC_INVERT_RESET)
  ) u_invert (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .sync_rst_in(soft_rst_any),
    .set_in(is_inv_set),
    .clr_in(is_inv_clr),
    .flag_out(invert_flag),
    .changed_out()
  );

  dibc_flag #(
    .RESET_VAL(DIBC_OUT_EN_RESET)
  ) u_out_en (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .sync_rst_in(soft_rst_any),
    .set_in(is_unblank),
    .clr_in(is_blank),
    .flag_out(out_en_flag),
    .changed_out()
  );

  // ----------------------------------------------------------------------
  // Panel outputs
  // ----------------------------------------------------------------------
  // Blank and unblank only touch the output-enable path; this block has no
  // frame memory port at all, so memory contents stay as they were
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      invert_out <= DIBC_INVERT_RESET;
    end else begin
      invert_out <= invert_flag;
    end
  end

  // Blank state follows the enable only at a frame start, so no command
  // cuts a part frame off mid-scan; a software reset blanks at once
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      blank_out <= DIBC_BLANK_RESET;
    end else if (soft_rst_any) begin
      blank_out <= DIBC_BLANK_RESET;
    end else if (frame_start_in) begin
      blank_out <= !out_en_flag;
    end
  end

  assign blank_pend = blank_out == out_en_flag;

  // ----------------------------------------------------------------------
  // Byte stream tracking
  // ----------------------------------------------------------------------
  // After one of our commands, data bytes are parameters nobody expects
  always_comb begin
    next_state = state;
    case (state)
      DIBC_IDLE,
      DIBC_OWN,
      DIBC_OTHER: begin
        if (exec_from_link) begin
          next_state = is_own ? DIBC_OWN : DIBC_OTHER;
        end
      end
      default: begin
        next_state = DIBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= DIBC_IDLE;
    end else if (soft_rst_any) begin
      state <= DIBC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign drop_now = byte_valid_in && !byte_is_cmd_in &&
                    (state == DIBC_OWN);

  // ----------------------------------------------------------------------
  // Forwarding to other decoders
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fwd_valid_out <= 1'b0;
      fwd_is_cmd_out <= 1'b0;
      fwd_byte_out <= 8'h00;
    end else begin
      fwd_valid_out <= byte_valid_in && !drop_now &&
                       !(exec_from_link && is_own);
      fwd_is_cmd_out <= byte_is_cmd_in;
      fwd_byte_out <= byte_in;
    end
  end

  // ----------------------------------------------------------------------
  // Diagnostics
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_cmd <= DIBC_LAST_CMD_RESET;
    end else if (is_own) begin
      last_cmd <= exec_byte;
    end
  end

  // Counter saturates instead of wrapping
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      drop_cnt <= DROP_CNT_W'(DIBC_DROP_CNT_RESET);
    end else if (soft_rst_any) begin
      drop_cnt <= DROP_CNT_W'(DIBC_DROP_CNT_RESET);
    end else if (drop_now && (drop_cnt != {DROP_CNT_W{1'b1}})) begin
      drop_cnt <= drop_cnt + DROP_CNT_W'(1);
    end
  end

  // Sticky drop flag: a new drop in the clearing cycle keeps it set
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      drop_seen <= 1'b0;
    end else if (drop_now) begin
      drop_seen <= 1'b1;
    end else if (reg_rd_in && (reg_addr_in == DIBC_REG_DROP_CNT)) begin
      drop_seen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  // Data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= '0;
    end else if (reg_addr_in == DIBC_REG_STATUS) begin
      reg_rdata_out <= '0;
      reg_rdata_out[DIBC_ST_INVERT_BIT] <= invert_flag;
      reg_rdata_out[DIBC_ST_OUT_EN_BIT] <= out_en_flag;
      reg_rdata_out[DIBC_ST_BLANK_BIT] <= blank_out;
      reg_rdata_out[DIBC_ST_BLANK_PEND_BIT] <= blank_pend;
      reg_rdata_out[DIBC_ST_SW_PEND_BIT] <= sw_cmd_pend;
      reg_rdata_out[DIBC_ST_DROP_BIT] <= drop_seen;
    end else if (reg_addr_in == DIBC_REG_LAST_CMD) begin
      reg_rdata_out <= last_cmd;
    end else if (reg_addr_in == DIBC_REG_DROP_CNT) begin
      reg_rdata_out <= DIBC_DATA_W'(drop_cnt);
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule : dibc_ctrl

`default_nettype wire

// [hw/dibc_pkg.sv]
// Constants and types for the inversion and blanking command block
`default_nettype none

package dibc_pkg;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] DIBC_INVERSION_CLEAR_CMD = 8'h20;
  localparam logic [7:0] DIBC_INVERSION_SET_CMD = 8'h21;
  localparam logic [7:0] DIBC_BLANK_OUTPUT_CMD = 8'h28;
  localparam logic [7:0] DIBC_UNBLANK_OUTPUT_CMD = 8'h29;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam int DIBC_ADDR_W = 4;
  localparam int DIBC_DATA_W = 8;
  localparam logic [3:0] DIBC_REG_STATUS = 4'h0;
  localparam logic [3:0] DIBC_REG_CMD_ISSUE = 4'h1;
  localparam logic [3:0] DIBC_REG_LAST_CMD = 4'h2;
  localparam logic [3:0] DIBC_REG_DROP_CNT = 4'h3;
  localparam logic [3:0] DIBC_REG_CTRL = 4'h4;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int DIBC_ST_INVERT_BIT = 0;
  localparam int DIBC_ST_OUT_EN_BIT = 1;
  localparam int DIBC_ST_BLANK_BIT = 2;
  localparam int DIBC_ST_BLANK_PEND_BIT = 3;
  localparam int DIBC_ST_SW_PEND_BIT = 4;
  localparam int DIBC_ST_DROP_BIT = 5;
  localparam int DIBC_CTRL_SOFT_RST_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic DIBC_INVERT_RESET = 1'b0;
  localparam logic DIBC_OUT_EN_RESET = 1'b0;
  localparam logic DIBC_BLANK_RESET = 1'b1;
  localparam logic [7:0] DIBC_LAST_CMD_RESET = 8'h00;
  localparam logic [7:0] DIBC_DROP_CNT_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Byte stream tracking state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DIBC_IDLE = 3'b001,
    DIBC_OWN = 3'b010,
    DIBC_OTHER = 3'b100
  } dibc_state_t;

endpackage : dibc_pkg

`default_nettype wire

// [hw/dibc_flag.sv]
// One set/clear state flag with reset value and change pulse
`default_nettype none

module dibc_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Control
  input wire logic sync_rst_in,
  input wire logic set_in,
  input wire logic clr_in,
  // State
  output logic flag_out,
  output logic changed_out
);

  // ----------------------------------------------------------------------
  // Flag
  // ----------------------------------------------------------------------
  // A request for the value already held leaves the flag alone
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_out <= RESET_VAL;
    end else if (sync_rst_in) begin
      flag_out <= RESET_VAL;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clr_in) begin
      flag_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Change pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      changed_out <= 1'b0;
    end else if (sync_rst_in) begin
      changed_out <= flag_out != RESET_VAL;
    end else begin
      changed_out <= (set_in && !flag_out) || (clr_in && !set_in && flag_out);
    end
  end

endmodule : dibc_flag

`default_nettype wire

// [test/dibc_ctrl_monitor.sv]
// Port checks for the inversion and blanking command decoder
`default_nettype none

module dibc_ctrl_monitor
  import dibc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Inputs
  input wire logic byte_valid_in,
  input wire logic byte_is_cmd_in,
  input wire logic [7:0] byte_in,
  input wire logic soft_rst_in,
  input wire logic frame_start_in,
  input wire logic [dibc_pkg::DIBC_ADDR_W-1:0] reg_addr_in,
  input wire logic [dibc_pkg::DIBC_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  // Outputs
  input wire logic invert_out,
  input wire logic blank_out,
  input wire logic fwd_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dibc_pkg::*;
  logic cmd;
  logic own;
  logic sw_rst;
  logic quiet;
  logic in_own;
  assign cmd = byte_valid_in && byte_is_cmd_in;
  assign own = cmd && byte_in inside {8'h20, 8'h21, 8'h28, 8'h29};
  assign sw_rst = soft_rst_in || (reg_wr_in && reg_addr_in == DIBC_REG_CTRL
    && reg_wdata_in[DIBC_CTRL_SOFT_RST_BIT]);
  assign quiet = !byte_valid_in && !reg_wr_in && !soft_rst_in;
  // Tracks the stretch after one of the four commands
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      in_own <= 1'b0;
    end else if (sw_rst || (cmd && !own)) begin
      in_own <= 1'b0;
    end else if (own) begin
      in_own <= 1'b1;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_inv_set_late: assert property (
    cmd && byte_in == 8'h21 && !sw_rst ##1 quiet |=> invert_out)
    else $error("inversion not set");
  a_inv_clr_late: assert property (
    cmd && byte_in == 8'h20 && !sw_rst ##1 quiet |=> !invert_out)
    else $error("inversion not cleared");
  a_blank_frame_gate: assert property (
    $changed(blank_out) |-> $past(frame_start_in) || $past(sw_rst))
    else $error("blank changed off frame boundary");
  a_blank_enter: assert property (
    cmd && byte_in == 8'h28 && !sw_rst ##1 quiet ##1 frame_start_in && quiet
    |=> blank_out) else $error("blank not entered");
  a_unblank_exit: assert property (
    cmd && byte_in == 8'h29 && !sw_rst ##1 quiet ##1 frame_start_in && quiet
    |=> !blank_out) else $error("blank not left");
  a_blank_keeps_inv: assert property (
    cmd && byte_in inside {8'h28, 8'h29} && !sw_rst ##1 quiet
    |=> $stable(invert_out))
    else $error("blank command moved inversion");
  a_drop_data: assert property (
    own || (byte_valid_in && !byte_is_cmd_in && in_own) |=> !fwd_valid_out)
    else $error("consumed byte forwarded");
  a_soft_blank: assert property (sw_rst |=> blank_out)
    else $error("soft reset left output on");
  a_soft_inv: assert property (sw_rst ##1 quiet |=> !invert_out)
    else $error("soft reset left inversion on");
  c_blank_cmd: cover property (cmd && byte_in == 8'h28);
  c_drop: cover property (in_own && byte_valid_in && !byte_is_cmd_in);
  c_inv_rise: cover property ($rose(invert_out));
endmodule : dibc_ctrl_monitor

bind dibc_ctrl dibc_ctrl_monitor u_mon (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .byte_valid_in(byte_valid_in),
  .byte_is_cmd_in(byte_is_cmd_in),
  .byte_in(byte_in),
  .soft_rst_in(soft_rst_in),
  .frame_start_in(frame_start_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .invert_out(invert_out),
  .blank_out(blank_out),
  .fwd_valid_out(fwd_valid_out)
);

`default_nettype wire

// [test/dibc_host_model.sv]
// Host processor that sends command and data bytes
`default_nettype none

module dibc_host_model (
  // Clock
  input wire logic core_clk_in,
  // Byte stream
  output logic byte_valid_out,
  output logic byte_is_cmd_out,
  output logic [7:0] byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    byte_valid_out = 1'b0;
    byte_is_cmd_out = 1'b0;
    byte_out = 8'h00;
  end
  // One flagged byte, no parameters; lines scrambled once released
  task automatic send(input logic [7:0] b, input logic c);
    @(posedge core_clk_in);
    byte_valid_out <= 1'b1;
    byte_is_cmd_out <= c;
    byte_out <= b;
    @(posedge core_clk_in);
    byte_valid_out <= 1'b0;
    byte_is_cmd_out <= ~c;
    byte_out <= ~b;
  endtask : send
endmodule : dibc_host_model

`default_nettype wire

// [test/dibc_ctrl_tb_top.sv]
// Testbench for the inversion and blanking command decoder
`default_nettype none

module dibc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dibc_pkg::*;
  typedef struct packed {
    logic [7:0] b;
    logic c;
    logic inv;
    logic blk;
    logic fwd;
  } dibc_row_t;
  logic core_clk_in;
  logic rst_in;
  logic soft_rst_in;
  logic frame_start_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic [7:0] reg_rdata_out;
  logic [7:0] byte_in;
  logic [7:0] fwd_byte_out;
  logic byte_valid_in;
  logic byte_is_cmd_in;
  logic invert_out;
  logic blank_out;
  logic fwd_valid_out;
  logic fwd_is_cmd_out;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  dibc_row_t rows [11] = '{
    '{8'h21, 1'b1, 1'b1, 1'b1, 1'b0},
    '{8'h21, 1'b1, 1'b1, 1'b1, 1'b0},
    '{8'h29, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h29, 1'b1, 1'b1, 1'b0, 1'b0},
    '{8'h55, 1'b0, 1'b1, 1'b0, 1'b0},
    '{8'h28, 1'b1, 1'b1, 1'b1, 1'b0},
    '{8'h28, 1'b1, 1'b1, 1'b1, 1'b0},
    '{8'h20, 1'b1, 1'b0, 1'b1, 1'b0},
    '{8'h20, 1'b1, 1'b0, 1'b1, 1'b0},
    '{8'h2c, 1'b1, 1'b0, 1'b1, 1'b1},
    '{8'h55, 1'b0, 1'b0, 1'b1, 1'b1}
  };

  dibc_host_model u_host (
    .core_clk_in(core_clk_in),
    .byte_valid_out(byte_valid_in),
    .byte_is_cmd_out(byte_is_cmd_in),
    .byte_out(byte_in)
  );

  dibc_ctrl uut (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .byte_valid_in(byte_valid_in),
    .byte_is_cmd_in(byte_is_cmd_in),
    .byte_in(byte_in),
    .soft_rst_in(soft_rst_in),
    .frame_start_in(frame_start_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .invert_out(invert_out),
    .blank_out(blank_out),
    .fwd_valid_out(fwd_valid_out),
    .fwd_is_cmd_out(fwd_is_cmd_out),
    .fwd_byte_out(fwd_byte_out)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic frame_pulse();
    @(posedge core_clk_in);
    frame_start_in <= 1'b1;
    @(posedge core_clk_in);
    frame_start_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask : frame_pulse

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk8(reg_rdata_out, exp);
  endtask : reg_read

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    rst_in = 1'b1;
    soft_rst_in = 1'b0;
    frame_start_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    chk1(invert_out, 1'b0);
    chk1(blank_out, 1'b1);
    foreach (rows[i]) begin
      u_host.send(rows[i].b, rows[i].c);
      // Forwarded copy stands only in the cycle after the byte is taken
      #1;
      chk1(fwd_valid_out, rows[i].fwd);
      if (rows[i].fwd) begin
        chk8(fwd_byte_out, rows[i].b);
        chk1(fwd_is_cmd_out, rows[i].c);
      end
      frame_pulse();
      chk1(invert_out, rows[i].inv);
      chk1(blank_out, rows[i].blk);
    end
    // Unblank held back until a frame boundary
    u_host.send(8'h29, 1'b1);
    repeat (4) @(posedge core_clk_in);
    #1;
    chk1(blank_out, 1'b1);
    frame_pulse();
    chk1(blank_out, 1'b0);
    // Command issued through the register port, then status
    reg_write(DIBC_REG_CMD_ISSUE, 8'h21);
    repeat (2) @(posedge core_clk_in);
    reg_read(DIBC_REG_STATUS, 8'h23);
    reg_read(DIBC_REG_DROP_CNT, 8'h01);
    reg_read(4'hf, 8'h00);
    reg_read(DIBC_REG_LAST_CMD, 8'h21);
    reg_read(DIBC_REG_STATUS, 8'h03);
    // Software pulse, control register and hardware reset
    for (int k = 0; k < 3; k++) begin
      u_host.send(8'h21, 1'b1);
      u_host.send(8'h29, 1'b1);
      frame_pulse();
      if (k == 1) begin
        reg_write(DIBC_REG_CTRL, 8'h01);
      end else begin
        @(posedge core_clk_in);
        soft_rst_in <= (k == 0);
        rst_in <= (k == 2);
        @(posedge core_clk_in);
        soft_rst_in <= 1'b0;
        rst_in <= 1'b0;
      end
      repeat (2) @(posedge core_clk_in);
      #1;
      chk1(invert_out, 1'b0);
      chk1(blank_out, 1'b1);
    end
    complete_run();
  end
endmodule : dibc_ctrl_tb_top

`default_nettype wire
